// ===== design/tvr_pkg.sv
// Constants shared by the telemetry value readout block
package tvr_pkg;
  // Avalon byte address width and register indices (byte address = 4 x index)
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned IDX_W = 16;
  localparam logic [15:0] IDX_REMOTE_B = 16'hFED6;
  localparam logic [15:0] IDX_TEMP_ONE = 16'hFED7;
  localparam logic [15:0] IDX_TEMP_TWO = 16'hFED8;
  localparam logic [15:0] IDX_LINE = 16'hFED9;
  localparam logic [15:0] IDX_DUTY_A = 16'hFEDA;
  localparam logic [15:0] IDX_DUTY_B = 16'hFEDB;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;
  // Field layout
  localparam int unsigned CODE_W = 12;
  localparam int unsigned LINE_W = 11;
  localparam int unsigned DUTY_W = 12;
  localparam int unsigned SENSE_LSB = 4;
  localparam int unsigned LINE_LSB = 5;
  localparam int unsigned LINE_SHIFT = 1;
  // Reset values
  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [10:0] LINE_RST = 11'h000;
  // Duty encoding: full scale count and divider start bit
  localparam logic [11:0] DUTY_FULL = 12'hFFF;
  localparam logic [11:0] DUTY_ZERO = 12'h000;
  localparam logic [3:0] DIV_TOP = 4'hB;
  localparam logic [3:0] DIV_LAST = 4'h0;
  // Candidate PWM pin positions in an assignment mask
  localparam int unsigned PIN_ONE = 0;
  localparam int unsigned PIN_TWO = 1;
  localparam int unsigned PIN_FIVE = 2;
  localparam int unsigned PIN_SIX = 3;
  localparam int unsigned PIN_N = 4;
  localparam int unsigned CH_N = 2;
  localparam int unsigned CH_A = 0;
  localparam int unsigned CH_B = 1;
  typedef enum logic {TVR_DIV_IDLE, TVR_DIV_RUN} tvr_div_e;
endpackage

// ===== design/tvr_readout.sv
// Telemetry value readout: sense result and duty cycle registers on Avalon-MM
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tvr_readout #(
  parameter int unsigned CNT_W = 16
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Converter results, same clock
  input wire logic [tvr_pkg::CODE_W-1:0] remote_voltage_sense_b_code_in,
  input wire logic remote_voltage_sense_b_valid_in,
  input wire logic [tvr_pkg::CODE_W-1:0] temp_sense_input_one_code_in,
  input wire logic temp_sense_input_one_valid_in,
  input wire logic [tvr_pkg::CODE_W-1:0] temp_sense_input_two_code_in,
  input wire logic temp_sense_input_two_valid_in,
  input wire logic [tvr_pkg::CODE_W-1:0] line_voltage_sense_code_in,
  input wire logic line_voltage_sense_valid_in,
  // PWM engine outputs and channel assignment, same clock
  input wire logic pwm_pin_one_in,
  input wire logic pwm_pin_two_in,
  input wire logic pwm_pin_five_in,
  input wire logic pwm_pin_six_in,
  input wire logic [tvr_pkg::PIN_N-1:0] chan_a_pin_assign_in,
  input wire logic [tvr_pkg::PIN_N-1:0] chan_b_pin_assign_in,
  // Avalon-MM slave
  input wire logic [tvr_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);
  import tvr_pkg::*;

  localparam int unsigned NUM_W = CNT_W + DUTY_W;

  ////////////////////////////////////////////////////////////////////////
  // Sense result registers

  logic [CODE_W-1:0] remote_b;
  logic [CODE_W-1:0] temp_one;
  logic [CODE_W-1:0] temp_two;
  logic [LINE_W-1:0] line_v;
  logic [CODE_W-1:0] next_remote_b;
  logic [CODE_W-1:0] next_temp_one;
  logic [CODE_W-1:0] next_temp_two;
  logic [LINE_W-1:0] next_line_v;

  // Whole code taken in one edge, so a read never sees a half update
  always_comb begin
    next_remote_b = remote_b;
    next_temp_one = temp_one;
    next_temp_two = temp_two;
    next_line_v = line_v;
    if (remote_voltage_sense_b_valid_in) begin
      next_remote_b = remote_voltage_sense_b_code_in;
    end
    if (temp_sense_input_one_valid_in) begin
      next_temp_one = temp_sense_input_one_code_in;
    end
    if (temp_sense_input_two_valid_in) begin
      next_temp_two = temp_sense_input_two_code_in;
    end
    if (line_voltage_sense_valid_in) begin
      // Twice the step of the 12-bit code, so drop its LSB
      next_line_v = line_voltage_sense_code_in[CODE_W-1:LINE_SHIFT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      remote_b <= CODE_RST;
      temp_one <= CODE_RST;
      temp_two <= CODE_RST;
      line_v <= LINE_RST;
    end else begin
      remote_b <= next_remote_b;
      temp_one <= next_temp_one;
      temp_two <= next_temp_two;
      line_v <= next_line_v;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Duty cycle measurement, one engine per regulated channel

  // Fixed priority among assigned candidate pins
  function automatic logic pick_pin(input logic [PIN_N-1:0] assign_mask, input logic [PIN_N-1:0] pins);
    logic lvl;
    lvl = 1'b0;
    if (assign_mask[PIN_ONE]) begin
      lvl = pins[PIN_ONE];
    end else if (assign_mask[PIN_TWO]) begin
      lvl = pins[PIN_TWO];
    end else if (assign_mask[PIN_FIVE]) begin
      lvl = pins[PIN_FIVE];
    end else if (assign_mask[PIN_SIX]) begin
      lvl = pins[PIN_SIX];
    end
    return lvl;
  endfunction

  logic [PIN_N-1:0] pins;
  logic sel_lvl [CH_N];
  logic prev [CH_N];
  logic seen [CH_N];
  logic [CNT_W-1:0] hi_cnt [CH_N];
  logic [CNT_W-1:0] per_cnt [CH_N];
  tvr_div_e div_st [CH_N];
  logic [3:0] div_bit [CH_N];
  logic [NUM_W-1:0] rem [CH_N];
  logic [CNT_W-1:0] den [CH_N];
  logic [DUTY_W-1:0] quot [CH_N];
  logic [DUTY_W-1:0] duty [CH_N];
  logic next_prev [CH_N];
  logic next_seen [CH_N];
  logic [CNT_W-1:0] next_hi_cnt [CH_N];
  logic [CNT_W-1:0] next_per_cnt [CH_N];
  tvr_div_e next_div_st [CH_N];
  logic [3:0] next_div_bit [CH_N];
  logic [NUM_W-1:0] next_rem [CH_N];
  logic [CNT_W-1:0] next_den [CH_N];
  logic [DUTY_W-1:0] next_quot [CH_N];
  logic [DUTY_W-1:0] next_duty [CH_N];
  logic rise [CH_N];
  logic sat [CH_N];

  assign pins = {pwm_pin_six_in, pwm_pin_five_in, pwm_pin_two_in, pwm_pin_one_in};
  assign sel_lvl[CH_A] = pick_pin(chan_a_pin_assign_in, pins);
  assign sel_lvl[CH_B] = pick_pin(chan_b_pin_assign_in, pins);

  // Period counts rising edge to rising edge; high time scaled by 0xFFF over it
  always_comb begin
    logic [NUM_W-1:0] dsh;
    dsh = '0;
    for (int c = 0; c < CH_N; c++) begin
      rise[c] = sel_lvl[c] & ~prev[c];
      sat[c] = &per_cnt[c];
      next_prev[c] = sel_lvl[c];
      next_seen[c] = seen[c] | rise[c];
      next_hi_cnt[c] = hi_cnt[c];
      next_per_cnt[c] = per_cnt[c];
      next_div_st[c] = div_st[c];
      next_div_bit[c] = div_bit[c];
      next_rem[c] = rem[c];
      next_den[c] = den[c];
      next_quot[c] = quot[c];
      next_duty[c] = duty[c];
      if (rise[c]) begin
        next_per_cnt[c] = CNT_W'(1);
        next_hi_cnt[c] = CNT_W'(1);
      end else if (!sat[c]) begin
        next_per_cnt[c] = per_cnt[c] + CNT_W'(1);
        if (sel_lvl[c]) begin
          next_hi_cnt[c] = hi_cnt[c] + CNT_W'(1);
        end
      end
      case (div_st[c])
        TVR_DIV_IDLE: begin
          if (rise[c] && seen[c] && !sat[c]) begin
            // hi * 0xFFF, quotient stays below 0x1000 as hi <= period
            next_rem[c] = {hi_cnt[c], DUTY_W'(0)} - NUM_W'(hi_cnt[c]);
            next_den[c] = per_cnt[c];
            next_div_bit[c] = DIV_TOP;
            next_quot[c] = DUTY_ZERO;
            next_div_st[c] = TVR_DIV_RUN;
          end else if (sat[c]) begin
            // No edge for a full count: steady level is 0 or 100 percent
            next_duty[c] = sel_lvl[c] ? DUTY_FULL : DUTY_ZERO;
          end
        end
        TVR_DIV_RUN: begin
          dsh = NUM_W'(den[c]) << div_bit[c];
          if (rem[c] >= dsh) begin
            next_rem[c] = rem[c] - dsh;
            next_quot[c][div_bit[c]] = 1'b1;
          end
          next_div_bit[c] = div_bit[c] - 4'h1;
          if (div_bit[c] == DIV_LAST) begin
            next_quot[c][div_bit[c]] = rem[c] >= dsh;
            next_duty[c] = next_quot[c];
            next_div_st[c] = TVR_DIV_IDLE;
          end
        end
        default: begin
          next_div_st[c] = TVR_DIV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    for (int c = 0; c < CH_N; c++) begin
      if (rst_in) begin
        prev[c] <= 1'b0;
        seen[c] <= 1'b0;
        hi_cnt[c] <= '0;
        per_cnt[c] <= '0;
        div_st[c] <= TVR_DIV_IDLE;
        div_bit[c] <= DIV_TOP;
        rem[c] <= '0;
        den[c] <= '0;
        quot[c] <= DUTY_ZERO;
        duty[c] <= DUTY_ZERO;
      end else begin
        prev[c] <= next_prev[c];
        seen[c] <= next_seen[c];
        hi_cnt[c] <= next_hi_cnt[c];
        per_cnt[c] <= next_per_cnt[c];
        div_st[c] <= next_div_st[c];
        div_bit[c] <= next_div_bit[c];
        rem[c] <= next_rem[c];
        den[c] <= next_den[c];
        quot[c] <= next_quot[c];
        duty[c] <= next_duty[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then data with waitrequest low

  logic [IDX_W-1:0] idx;
  logic req;
  logic [15:0] sel_val;
  logic [31:0] next_rdata;
  logic next_wait;

  assign idx = avs_address_in[ADDR_W-1:2];
  assign req = avs_read_in | avs_write_in;

  // Writes are accepted and dropped: every register here is read-only
  always_comb begin
    sel_val = 16'h0000;
    if (avs_address_in[1:0] == ADDR_ALIGN) begin
      case (idx)
        IDX_REMOTE_B: sel_val = {remote_b, 4'h0};
        IDX_TEMP_ONE: sel_val = {temp_one, 4'h0};
        IDX_TEMP_TWO: sel_val = {temp_two, 4'h0};
        IDX_LINE: sel_val = {line_v, 5'h00};
        IDX_DUTY_A: sel_val = {duty[CH_A], 4'h0};
        IDX_DUTY_B: sel_val = {duty[CH_B], 4'h0};
        default: sel_val = 16'h0000;
      endcase
    end
    next_wait = !(req && avs_waitrequest_out);
    next_rdata = avs_readdata_out;
    if (avs_read_in && avs_waitrequest_out) begin
      next_rdata = {16'h0000, sel_val};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_readdata_out <= next_rdata;
      avs_waitrequest_out <= next_wait;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_read_held;
    avs_read_in && avs_waitrequest_out;
  endsequence
  sequence s_read_done;
    !avs_waitrequest_out && avs_readdata_out[31:16] == 16'h0000;
  endsequence

  a_remote_b_load: assert property (remote_voltage_sense_b_valid_in |=>
    remote_b == $past(remote_voltage_sense_b_code_in)) else $error("remote B result not stored");
  a_zero_reads_zero: assert property (temp_sense_input_one_valid_in && temp_sense_input_one_code_in == 12'h000
    |=> temp_one == 12'h000) else $error("zero input not stored as zero");
  a_temp_two_hold: assert property (!temp_sense_input_two_valid_in |=> $stable(temp_two))
    else $error("temperature two changed without a result");
  a_line_scale: assert property (line_voltage_sense_valid_in && line_voltage_sense_code_in == 12'hA00
    |=> line_v == 11'h500) else $error("line voltage scaling wrong");
  a_div_a_bound: assert property (div_st[CH_A] == TVR_DIV_IDLE ##1 div_st[CH_A] == TVR_DIV_RUN
    |-> ##[1:12] div_st[CH_A] == TVR_DIV_IDLE) else $error("channel A divide overran");
  a_div_b_bound: assert property (div_st[CH_B] == TVR_DIV_IDLE ##1 div_st[CH_B] == TVR_DIV_RUN
    |-> ##12 div_st[CH_B] == TVR_DIV_IDLE) else $error("channel B divide length wrong");
  a_pin_priority: assert property (chan_a_pin_assign_in[PIN_ONE] |-> sel_lvl[CH_A] == pwm_pin_one_in)
    else $error("pin one not preferred");
  a_pin_second: assert property (chan_b_pin_assign_in == 4'hC |-> sel_lvl[CH_B] == pwm_pin_five_in)
    else $error("pin five not preferred over six");
  a_full_duty: assert property (div_st[CH_A] == TVR_DIV_IDLE && sat[CH_A] && sel_lvl[CH_A]
    |=> duty[CH_A] == DUTY_FULL) else $error("steady high not full scale");
  a_read_answer: assert property (s_read_held |=> s_read_done)
    else $error("read not answered in one wait cycle");
  a_read_no_effect: assert property (avs_read_in && !remote_voltage_sense_b_valid_in
    |=> $stable(remote_b)) else $error("read changed a value");
endmodule
`default_nettype wire

// ===== tb/tvr_readout_tb_top.sv
// Self-checking testbench for the telemetry value readout registers
`timescale 1ns/1ps
`default_nettype none
module tvr_readout_tb_top;
  import tvr_pkg::*;
  logic clk;
  logic rst;
  logic [11:0] code [4];
  logic [3:0] vld;
  logic [3:0] pwm;
  logic [3:0] assign_a;
  logic [3:0] assign_b;
  logic [17:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [6:0] phase;
  int hi [4];
  int mismatches;
  int total_checks;
  logic [31:0] rd;

  tvr_readout #(.CNT_W(8)) u_dut (
    .core_clk_in(clk), .rst_in(rst),
    .remote_voltage_sense_b_code_in(code[0]), .remote_voltage_sense_b_valid_in(vld[0]),
    .temp_sense_input_one_code_in(code[1]), .temp_sense_input_one_valid_in(vld[1]),
    .temp_sense_input_two_code_in(code[2]), .temp_sense_input_two_valid_in(vld[2]),
    .line_voltage_sense_code_in(code[3]), .line_voltage_sense_valid_in(vld[3]),
    .pwm_pin_one_in(pwm[0]), .pwm_pin_two_in(pwm[1]), .pwm_pin_five_in(pwm[2]), .pwm_pin_six_in(pwm[3]),
    .chan_a_pin_assign_in(assign_a), .chan_b_pin_assign_in(assign_b),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PWM source: 100-cycle period, per-pin high width; 100 holds high, 0 holds low
  always @(posedge clk) begin
    if (rst) begin
      phase <= 7'd0;
    end else begin
      phase <= (phase == 7'd99) ? 7'd0 : phase + 7'd1;
    end
    for (int i = 0; i < 4; i++) begin
      pwm[i] <= (int'(phase) < hi[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One edge of gap first, so a released strobe is never re-raised in the same step
  task automatic bus_op(input logic wr, input logic [15:0] idx, input logic [1:0] off,
                        input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, off};
    avs_writedata <= wd;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) check(1'b1, 1'b0, "bus answer timeout");
  endtask

  task automatic read_check(input logic [15:0] idx, input logic [1:0] off, input logic [15:0] exp,
                            input string msg);
    logic [31:0] d;
    bus_op(1'b0, idx, off, 32'h0, d);
    check(d, {16'h0000, exp}, msg);
  endtask

  task automatic load(input int ch, input logic [11:0] c);
    @(posedge clk);
    code[ch] <= c;
    vld[ch] <= 1'b1;
    @(posedge clk);
    vld <= 4'h0;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] vals [4];
    logic [15:0] exp;
    rst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      code[i] = 12'h000;
      hi[i] = 0;
    end
    vld = 4'h0;
    assign_a = 4'h3;
    assign_b = 4'hC;
    avs_address = 18'h00000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    mismatches = 0;
    total_checks = 0;
    vals = '{12'hA00, 12'h123, 12'hFFF, 12'h000};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 6; r++) begin
      read_check(IDX_REMOTE_B + 16'(r), 2'h0, 16'h0000, "value after reset");
    end
    $display("test reset done");
    // Each code on every sense input, line input keeps only its top 11 bits
    for (int v = 0; v < 4; v++) begin
      for (int ch = 0; ch < 4; ch++) begin
        load(ch, vals[v]);
        exp = (ch == 3) ? {vals[v][11:1], 5'h00} : {vals[v], 4'h0};
        read_check(IDX_REMOTE_B + 16'(ch), 2'h0, exp, "sense value");
      end
    end
    $display("test sense done");
    load(0, 12'hA00);
    bus_op(1'b1, IDX_REMOTE_B, 2'h0, 32'h0000FFFF, rd);
    read_check(IDX_REMOTE_B, 2'h0, 16'hA000, "write ignored");
    read_check(IDX_REMOTE_B, 2'h0, 16'hA000, "read repeat");
    read_check(IDX_DUTY_B + 16'h0001, 2'h0, 16'h0000, "unmapped read");
    read_check(IDX_REMOTE_B, 2'h1, 16'h0000, "misaligned read");
    $display("test bus done");
    // Two candidates per channel, then one: the higher-priority assigned pin must be measured
    @(posedge clk);
    hi[0] <= 25;
    hi[1] <= 75;
    hi[2] <= 50;
    hi[3] <= 10;
    repeat (400) @(posedge clk);
    read_check(IDX_DUTY_A, 2'h0, 16'h3FF0, "duty a pin one");
    read_check(IDX_DUTY_B, 2'h0, 16'h7FF0, "duty b pin five");
    @(posedge clk);
    assign_a <= 4'h2;
    assign_b <= 4'h8;
    repeat (400) @(posedge clk);
    read_check(IDX_DUTY_A, 2'h0, 16'hBFF0, "duty a pin two");
    read_check(IDX_DUTY_B, 2'h0, 16'h1990, "duty b pin six");
    // Steady levels: no edges, so the counter saturates
    @(posedge clk);
    hi[1] <= 100;
    hi[3] <= 0;
    repeat (600) @(posedge clk);
    read_check(IDX_DUTY_A, 2'h0, 16'hFFF0, "duty full scale");
    read_check(IDX_DUTY_B, 2'h0, 16'h0000, "duty zero");
    $display("test duty done");
    summarize();
  end

  // Whole run needs about 1500 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
